// ===== include/mti_regs.vh
// mti_regs.vh: constants of the motion task i/o interface
// assumes inclusion by bare name from the design files
`ifndef MTI_REGS_VH
`define MTI_REGS_VH

// block number width and the "no task selected" code
`define MTI_BLK_W 8
`define MTI_BLK_NONE 8'h00

// command codes to the motion core; homing is run as its own internal task code
`define MTI_CMD_W 3
`define MTI_CMD_IDLE 3'h0
`define MTI_CMD_START 3'h1
`define MTI_CMD_HOME 3'h2
`define MTI_CMD_RESUME 3'h3
`define MTI_CMD_FOLLOW 3'h4
`define MTI_CMD_JOG 3'h5
`define MTI_CMD_JOG_STOP 3'h6

// position compare outputs
`define MTI_PCMP_N 6
`define MTI_PCMP_SWLIM1 1
`define MTI_PCMP_SWLIM2 2

// synchroniser depth
`define MTI_SYNC_N 2

`endif

// ===== verilog/mti_sync_edge.v
// mti_sync_edge.v: two flop synchroniser with edge detect for one pin
// assumes an asynchronous pin input and one system clock
`timescale 1ns/100ps

module mti_sync_edge (
   input wire clock_in,
   input wire rst_n_in,
   input wire pin_in,
   output wire level_out,
   output wire rise_out,
   output wire fall_out
);

   reg meta_r;
   reg sync_r;
   reg last_r;

   // only sync_r reads meta_r; edges come from the settled copies
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   // edge pulses last one cycle
   assign level_out = sync_r;
   assign rise_out = sync_r & ~last_r;
   assign fall_out = ~sync_r & last_r;

endmodule

// ===== verilog/mti_top.v
// mti_top.v: parallel i/o front end that starts and reports motion tasks
// assumes pins are asynchronous, motion core on clock_in answers with levels
// How it works
// - follow-on start launches the next i/o-started task only once the target is reached.
// - jog rising edge starts jog at stored speed, falling edge cancels it.
// - task resume continues the interrupted task instead of a new one.
// - task launch starts the task numbered on the block number lines, captured at launch.
// - launch with no task number selected runs homing instead.
// - target reached output is high while the axis is inside the in-position window.
// - sequence step output toggles at the start of each task after the first of an automatic sequence.
// - the first task of a sequence drives the sequence step output low.
// - following error output goes low when deviation leaves its window and stays low until error clear.
// - position compare output one reports software limit one high by default.
// - position compare output two reports software limit two high by default.
// - compare outputs zero, three, four, five follow text-configured sources only.
// - block number line zero is the lsb and line seven the msb.
// - error clear removes a pending following error or response warning.
`timescale 1ns/100ps
`include "mti_regs.vh"

module mti_top (
   input wire clock_in,
   input wire rst_n_in,
   input wire [7:0] block_number_lines_in,
   input wire task_launch_signal_in,
   input wire task_resume_input_in,
   input wire follow_start_in,
   input wire jog_in,
   input wire error_clear_in,
   input wire home_switch_in,
   input wire in_window_in,
   input wire follow_error_in,
   input wire resp_error_in,
   input wire seq_auto_in,
   input wire seq_task_start_in,
   input wire seq_first_in,
   input wire next_is_io_in,
   input wire task_interrupted_in,
   input wire swlim1_in,
   input wire swlim2_in,
   input wire [5:0] pcmp_cfg_src_in,
   input wire [1:0] pcmp_sel_in,
   output reg [2:0] cmd_out,
   output reg cmd_valid_out,
   output reg [7:0] cmd_block_out,
   output reg jog_active_out,
   output reg home_switch_out,
   output reg target_reached_out,
   output reg sequence_step_toggle_out,
   output reg follow_error_n_out,
   output reg resp_warn_out,
   output reg position_compare_out0,
   output reg position_compare_out1,
   output reg position_compare_out2,
   output reg position_compare_out3,
   output reg position_compare_out4,
   output reg position_compare_out5
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   wire [7:0] blk_sync;
   wire [7:0] blk_rise_unused;
   wire [7:0] blk_fall_unused;
   wire launch_lvl, launch_rise, launch_fall;
   wire resume_lvl, resume_rise, resume_fall;
   wire follow_lvl, follow_rise, follow_fall;
   wire jog_lvl, jog_rise, jog_fall;
   wire clr_lvl, clr_rise, clr_fall;
   wire home_lvl, home_rise, home_fall;

   genvar gi;
   // each block number bit synchronised alike, bit index keeps weight
   generate
      for (gi = 0; gi < `MTI_BLK_W; gi = gi + 1) begin : g_blk
         mti_sync_edge u_blk (
            .clock_in(clock_in),
            .rst_n_in(rst_n_in),
            .pin_in(block_number_lines_in[gi]),
            .level_out(blk_sync[gi]),
            .rise_out(blk_rise_unused[gi]),
            .fall_out(blk_fall_unused[gi])
         );
      end
   endgenerate

   mti_sync_edge u_launch (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .pin_in(task_launch_signal_in), .level_out(launch_lvl),
      .rise_out(launch_rise), .fall_out(launch_fall));
   mti_sync_edge u_resume (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .pin_in(task_resume_input_in), .level_out(resume_lvl),
      .rise_out(resume_rise), .fall_out(resume_fall));
   mti_sync_edge u_follow (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .pin_in(follow_start_in), .level_out(follow_lvl),
      .rise_out(follow_rise), .fall_out(follow_fall));
   mti_sync_edge u_jog (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .pin_in(jog_in), .level_out(jog_lvl),
      .rise_out(jog_rise), .fall_out(jog_fall));
   mti_sync_edge u_clr (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .pin_in(error_clear_in), .level_out(clr_lvl),
      .rise_out(clr_rise), .fall_out(clr_fall));
   mti_sync_edge u_home (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .pin_in(home_switch_in), .level_out(home_lvl),
      .rise_out(home_rise), .fall_out(home_fall));

   ////////////////////////////////////////////////////////////////////////
   // command arbitration

   // follow-on request waits here until the target is reached
   reg follow_pend_r;
   wire follow_fire = (follow_pend_r | follow_rise) & in_window_in & next_is_io_in;

   reg [2:0] cmd_nxt;
   reg [7:0] blk_nxt;
   // priority: jog edges, launch, resume, follow-on
   always @* begin
      cmd_nxt = `MTI_CMD_IDLE;
      blk_nxt = cmd_block_out;
      if (jog_rise) begin
         cmd_nxt = `MTI_CMD_JOG;
      end else if (jog_fall) begin
         cmd_nxt = `MTI_CMD_JOG_STOP;
      end else if (launch_rise) begin
         blk_nxt = blk_sync;
         if (blk_sync == `MTI_BLK_NONE) begin
            cmd_nxt = `MTI_CMD_HOME;
         end else begin
            cmd_nxt = `MTI_CMD_START;
         end
      end else if (resume_rise && task_interrupted_in) begin
         cmd_nxt = `MTI_CMD_RESUME;
      end else if (follow_fire) begin
         cmd_nxt = `MTI_CMD_FOLLOW;
      end
   end

   // command strobe lasts one cycle, block number held until next launch
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_out <= `MTI_CMD_IDLE;
         cmd_valid_out <= 1'b0;
         cmd_block_out <= `MTI_BLK_NONE;
      end else begin
         cmd_out <= cmd_nxt;
         cmd_valid_out <= (cmd_nxt != `MTI_CMD_IDLE);
         cmd_block_out <= blk_nxt;
      end
   end

   // pending follow-on: an issue in the same cycle beats a new request, cleared only when it is issued
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         follow_pend_r <= 1'b0;
      end else if (follow_rise && (cmd_nxt != `MTI_CMD_FOLLOW)) begin
         follow_pend_r <= 1'b1;
      end else if (cmd_nxt == `MTI_CMD_FOLLOW) begin
         follow_pend_r <= 1'b0;
      end
   end

   // jog runs between rising and falling edge
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         jog_active_out <= 1'b0;
      end else if (jog_rise) begin
         jog_active_out <= 1'b1;
      end else if (jog_fall) begin
         jog_active_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status outputs

   // warnings are sticky; a new error beats a clear in the same cycle
   reg ferr_warn_r;
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ferr_warn_r <= 1'b0;
         resp_warn_out <= 1'b0;
      end else begin
         if (follow_error_in) begin
            ferr_warn_r <= 1'b1;
         end else if (clr_rise) begin
            ferr_warn_r <= 1'b0;
         end
         if (resp_error_in) begin
            resp_warn_out <= 1'b1;
         end else if (clr_rise) begin
            resp_warn_out <= 1'b0;
         end
      end
   end

   // no cable break detection on the in-position line
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         target_reached_out <= 1'b0;
         follow_error_n_out <= 1'b1;
         home_switch_out <= 1'b0;
      end else begin
         target_reached_out <= in_window_in;
         follow_error_n_out <= ~ferr_warn_r;
         home_switch_out <= home_lvl;
      end
   end

   // sequence step: first task forces low, later starts invert
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sequence_step_toggle_out <= 1'b0;
      end else if (seq_auto_in && seq_task_start_in) begin
         if (seq_first_in) begin
            sequence_step_toggle_out <= 1'b0;
         end else begin
            sequence_step_toggle_out <= ~sequence_step_toggle_out;
         end
      end
   end

   // sel bit 0 hands output 1 and sel bit 1 hands output 2 to configured sources; a clear bit keeps its default limit
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         position_compare_out0 <= 1'b0;
         position_compare_out1 <= 1'b0;
         position_compare_out2 <= 1'b0;
         position_compare_out3 <= 1'b0;
         position_compare_out4 <= 1'b0;
         position_compare_out5 <= 1'b0;
      end else begin
         position_compare_out0 <= pcmp_cfg_src_in[0];
         position_compare_out1 <= pcmp_sel_in[0] ? pcmp_cfg_src_in[1] : swlim1_in;
         position_compare_out2 <= pcmp_sel_in[1] ? pcmp_cfg_src_in[2] : swlim2_in;
         position_compare_out3 <= pcmp_cfg_src_in[3];
         position_compare_out4 <= pcmp_cfg_src_in[4];
         position_compare_out5 <= pcmp_cfg_src_in[5];
      end
   end

endmodule

// ===== test/mti_top_assertions.sv
// mti_top_assertions.sv: port timing checks for mti_top
// assumes pins move just after a clock edge, three edges to a command
`timescale 1ns/100ps
`include "mti_regs.vh"
module mti_chk (
   input wire clock_in,
   input wire rst_n_in,
   input wire [7:0] block_number_lines_in,
   input wire task_launch_signal_in,
   input wire task_resume_input_in,
   input wire jog_in,
   input wire error_clear_in,
   input wire in_window_in,
   input wire follow_error_in,
   input wire seq_auto_in,
   input wire seq_task_start_in,
   input wire seq_first_in,
   input wire task_interrupted_in,
   input wire [2:0] cmd_out,
   input wire cmd_valid_out,
   input wire [7:0] cmd_block_out,
   input wire target_reached_out,
   input wire sequence_step_toggle_out,
   input wire follow_error_n_out
);
   // one domain, so clock and reset are given once
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////
   chk_in_pos: assert property ($past(rst_n_in) |-> target_reached_out == $past(in_window_in))
      else $error("in position wrong");
   chk_launch_blk: assert property ($rose(task_launch_signal_in) && $stable(jog_in)
      |-> ##3 cmd_valid_out && cmd_block_out == $past(block_number_lines_in, 3))
      else $error("launch block wrong");
   chk_home_sel: assert property ($rose(task_launch_signal_in) && $stable(jog_in)
      && block_number_lines_in == 8'h00 |-> ##3 cmd_out == `MTI_CMD_HOME)
      else $error("homing not chosen");
   chk_jog_edges: assert property (!$stable(jog_in) |-> ##3 cmd_valid_out
      && cmd_out == ($past(jog_in, 3) ? `MTI_CMD_JOG : `MTI_CMD_JOG_STOP))
      else $error("jog command wrong");
   chk_resume_gate: assert property ($rose(task_resume_input_in)
      |-> ##3 cmd_valid_out == task_interrupted_in)
      else $error("resume gating wrong");
   chk_seq_first: assert property (seq_auto_in && seq_task_start_in && seq_first_in
      |=> !sequence_step_toggle_out)
      else $error("first step not low");
   chk_seq_toggle: assert property (seq_auto_in && seq_task_start_in && !seq_first_in
      |=> sequence_step_toggle_out != $past(sequence_step_toggle_out))
      else $error("step did not toggle");
   chk_ferr_low: assert property (follow_error_in |-> ##2 !follow_error_n_out)
      else $error("following error not low");
   chk_err_clear: assert property ($rose(error_clear_in) ##0 (!follow_error_in)[*5]
      |-> follow_error_n_out)
      else $error("warning not cleared");
   // main scenarios reached
   cover property ($rose(task_launch_signal_in) ##2 cmd_valid_out);
   cover property (seq_task_start_in && seq_first_in);
   cover property (!follow_error_n_out ##1 follow_error_n_out);
endmodule
bind mti_top mti_chk u_chk (.*);

// ===== test/mti_plc_model.sv
// mti_plc_model.sv: controller side driving the task pins
// assumes the bench calls drive and the pins feed mti_top
`timescale 1ns/100ps
module mti_plc_model (
   input wire clock_in,
   output reg [7:0] block_number_lines_out = 8'h00,
   output reg [5:0] pins_out = 6'h00
);
   ////////////////////////////////////////
   // pins: 0 launch, 1 resume, 2 follow, 3 jog, 4 clear, 5 home
   // block is set three edges early so it is settled when the pin moves
   task drive(input integer pin, input logic val, input logic [7:0] blk);
      begin
         @(posedge clock_in);
         block_number_lines_out <= blk;
         repeat (3) @(posedge clock_in);
         pins_out[pin] <= val;
      end
   endtask
endmodule

// ===== test/mti_top_tb_top.sv
// mti_top_tb_top.sv: directed bench for mti_top
// assumes the designer's command codes and two-edge pin latency
`timescale 1ns/100ps
`include "mti_regs.vh"
module mti_top_tb_top;
   reg clock_in = 1'b0, rst_n_in = 1'b0, in_window_in = 1'b0, follow_error_in = 1'b0;
   reg resp_error_in = 1'b0, seq_auto_in = 1'b0, seq_task_start_in = 1'b0, seq_first_in = 1'b0;
   reg next_is_io_in = 1'b0, task_interrupted_in = 1'b0, swlim1_in = 1'b0, swlim2_in = 1'b0;
   reg [5:0] pcmp_cfg_src_in = 6'h00;
   wire [7:0] blk, cmd_block_out;
   wire [5:0] pins, pc;
   wire [2:0] cmd_out;
   wire cmd_valid_out, jog_active_out, home_switch_out, target_reached_out;
   wire sequence_step_toggle_out, follow_error_n_out, resp_warn_out;
   integer n_fail = 0, compares = 0, i;
   // 100 MHz clock
   always #5 clock_in = ~clock_in;
   mti_plc_model u_plc (.clock_in, .block_number_lines_out(blk), .pins_out(pins));
   mti_top u_dut (.clock_in, .rst_n_in, .block_number_lines_in(blk),
      .task_launch_signal_in(pins[0]), .task_resume_input_in(pins[1]),
      .follow_start_in(pins[2]), .jog_in(pins[3]), .error_clear_in(pins[4]),
      .home_switch_in(pins[5]), .in_window_in, .follow_error_in, .resp_error_in,
      .seq_auto_in, .seq_task_start_in, .seq_first_in, .next_is_io_in,
      .task_interrupted_in, .swlim1_in, .swlim2_in, .pcmp_cfg_src_in, .pcmp_sel_in(2'h0),
      .cmd_out, .cmd_valid_out, .cmd_block_out, .jog_active_out, .home_switch_out,
      .target_reached_out, .sequence_step_toggle_out, .follow_error_n_out, .resp_warn_out,
      .position_compare_out0(pc[0]), .position_compare_out1(pc[1]),
      .position_compare_out2(pc[2]), .position_compare_out3(pc[3]),
      .position_compare_out4(pc[4]), .position_compare_out5(pc[5]));
   ////////////////////////////////////////
   task check(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // idle code means no command may appear in the window
   task expect_cmd(input [2:0] code, input [7:0] b);
      integer k;
      reg seen;
      begin
         seen = 1'b0;
         for (k = 0; k < 6 && !seen; k = k + 1) begin
            @(posedge clock_in) #1;
            if (cmd_valid_out === 1'b1) begin
               seen = 1'b1;
               check(cmd_out, code);
               if (code == `MTI_CMD_START) check(cmd_block_out, b);
            end
         end
         check(seen, code != `MTI_CMD_IDLE);
      end
   endtask
   task pulse(input integer pin, input [7:0] b, input [2:0] code);
      begin
         u_plc.drive(pin, 1'b1, b);
         expect_cmd(code, b);
         u_plc.drive(pin, 1'b0, b);
      end
   endtask
   task results;
      begin
         $display("compares %0d n_fail %0d", compares, n_fail);
         if (n_fail == 0 && compares > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   // watchdog well beyond the roughly 150 cycles the tests need
   initial begin
      #100000;
      n_fail = n_fail + 1;
      results;
   end
   // main sequence
   initial begin
      repeat (3) @(posedge clock_in);
      #1 check(follow_error_n_out, 8'h01);
      check(cmd_valid_out, 8'h00);
      @(posedge clock_in) rst_n_in <= 1'b1;
      pulse(0, 8'hAE, `MTI_CMD_START);
      pulse(0, 8'h00, `MTI_CMD_HOME);
      pulse(0, 8'h80, `MTI_CMD_START);
      pulse(0, 8'h01, `MTI_CMD_START);
      u_plc.drive(3, 1'b1, 8'h01);
      expect_cmd(`MTI_CMD_JOG, 8'h00);
      @(posedge clock_in) #1 check(jog_active_out, 8'h01);
      u_plc.drive(3, 1'b0, 8'h01);
      expect_cmd(`MTI_CMD_JOG_STOP, 8'h00);
      @(posedge clock_in) #1 check(jog_active_out, 8'h00);
      pulse(1, 8'h01, `MTI_CMD_IDLE);
      @(posedge clock_in) task_interrupted_in <= 1'b1;
      pulse(1, 8'h01, `MTI_CMD_RESUME);
      @(posedge clock_in) next_is_io_in <= 1'b1;
      pulse(2, 8'h01, `MTI_CMD_IDLE);
      @(posedge clock_in) in_window_in <= 1'b1;
      expect_cmd(`MTI_CMD_FOLLOW, 8'h00);
      check(target_reached_out, 8'h01);
      // first, toggle, first, toggle, toggle
      seq_auto_in <= 1'b1;
      for (i = 0; i < 5; i = i + 1) begin
         @(posedge clock_in);
         seq_task_start_in <= 1'b1;
         seq_first_in <= (i == 0 || i == 2);
         @(posedge clock_in) seq_task_start_in <= 1'b0;
         #1 check(sequence_step_toggle_out, (i == 1 || i == 3));
      end
      follow_error_in <= 1'b1;
      resp_error_in <= 1'b1;
      @(posedge clock_in) follow_error_in <= 1'b0;
      resp_error_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      #1 check(follow_error_n_out, 8'h00);
      check(resp_warn_out, 8'h01);
      pulse(4, 8'h01, `MTI_CMD_IDLE);
      check(follow_error_n_out, 8'h01);
      check(resp_warn_out, 8'h00);
      swlim1_in <= 1'b1;
      pcmp_cfg_src_in <= 6'h39;
      u_plc.drive(5, 1'b1, 8'h01);
      repeat (4) @(posedge clock_in);
      #1 check(pc, 8'h3B);
      check(home_switch_out, 8'h01);
      results;
   end
endmodule
